// file: rtl/icsv_map.svh
// register offsets, field positions and reset values of the control block
`ifndef ICSV_MAP_SVH
`define ICSV_MAP_SVH
// register indices; byte address is four times the index
`define ICSV_IDX_CTRL   8'h16
`define ICSV_IDX_STAT   8'h17
`define ICSV_IDX_MASK   8'h18
// control register fields
`define ICSV_B_INT      15
`define ICSV_B_THR_HI   14
`define ICSV_B_THR_LO   13
`define ICSV_B_VEC_HI   12
`define ICSV_B_VEC_LO   6
`define ICSV_B_DIS      5
`define ICSV_RSV_ONES   3'h7
`define ICSV_RSV_ZEROS  2'h0
`define ICSV_RST_DIS    1'h0
`define ICSV_RST_THR    2'h0
`define ICSV_RST_VEC    7'h00
// event bits in status and mask
`define ICSV_EV_TAKEN   0
`define ICSV_EV_BLOCK   1
`define ICSV_EV_W       2
`define ICSV_RST_MASK   2'h0
// release hold: reset vector stays until the second edge after release
`define ICSV_HOLD_EDGES 1'h1
`endif

// file: rtl/icsv_pkg.sv
// types shared by the interrupt control and status block
package icsv_pkg;
	// request offered by the priority logic
	typedef struct packed {
		logic        valid;  // a request is waiting
		logic        lowest_priority_sw_request;  // lowest priority software request
		logic [1:0]  level;  // priority level 0..3
		logic [20:0] addr;   // table vector or fast jump address
	} icsv_req_t;
	// presenter states, one-hot
	typedef enum logic [1:0] {
		ST_IDLE    = 2'h1,
		ST_PRESENT = 2'h2
	} icsv_st_t;
endpackage : icsv_pkg

// file: rtl/icsv_ctrl.sv
// interrupt control/status register, core request presenter, reset vector
`include "icsv_map.svh"
`timescale 1ns/1ps
`default_nettype none

module icsv_ctrl #(
	parameter logic [20:0] RESET_VEC = 21'h000000  // reset vector address
) (
	input  wire logic                 clk,
	input  wire logic                 reset,
	input  wire logic                 ce,
	// apb slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic                      pready,
	output logic [31:0]               prdata,
	output logic                      pslverr,
	// request from priority logic
	input  wire icsv_pkg::icsv_req_t  req,
	// core side
	input  wire logic                 core_ack,
	output logic                      core_irq,
	output logic [1:0]                core_level,
	output logic [20:0]               vector_address_bus,
	// event interrupt
	output logic                      irq
);

	////////////////////////////////////////////////////////////////////////
	// state
	icsv_pkg::icsv_st_t  st_q;           // presenter state
	icsv_pkg::icsv_st_t  st_d;
	logic                hold_q;         // reset vector still forced
	logic                hold_d;
	logic                dis_q;          // global_irq_disable
	logic                dis_d;
	logic [1:0]          thr_q;          // nest_priority_threshold
	logic [1:0]          thr_d;
	logic [6:0]          vec_q;          // vector number field
	logic [6:0]          vec_d;
	logic [20:0]         vab_q;          // vector_address_bus drive
	logic [20:0]         vab_d;
	logic [1:0]          lvl_q;          // level being presented
	logic [1:0]          lvl_d;
	logic [1:0]          lvl_thr_q;      // threshold code of presented request
	logic [1:0]          lvl_thr_d;
	logic [`ICSV_EV_W-1:0] stat_q;       // sticky events
	logic [`ICSV_EV_W-1:0] stat_d;
	logic [`ICSV_EV_W-1:0] mask_q;       // event mask
	logic [`ICSV_EV_W-1:0] mask_d;
	logic                irq_q;
	logic                irq_d;
	logic                rdy_q;          // apb answer
	logic                rdy_d;
	logic [31:0]         rd_q;
	logic [31:0]         rd_d;
	logic                err_q;
	logic                err_d;

	////////////////////////////////////////////////////////////////////////
	// decode helpers
	logic                acc;            // access phase, answer not yet given
	logic                done;           // transfer completes this edge
	logic                hit_ctrl;
	logic                hit_stat;
	logic                hit_mask;
	logic                mapped;
	logic                admit;          // request may be presented
	logic [1:0]          new_thr;        // threshold code after entry
	logic [15:0]         ctrl_rd;        // control register read image
	logic [`ICSV_EV_W-1:0] ev;          // events this cycle

	// decode: byte address is four times the register index, upper bits zero
	always_comb begin
		acc      = psel & penable & ~rdy_q;
		done     = psel & penable & rdy_q;
		hit_ctrl = (paddr == {2'h0, `ICSV_IDX_CTRL, 2'h0});
		hit_stat = (paddr == {2'h0, `ICSV_IDX_STAT, 2'h0});
		hit_mask = (paddr == {2'h0, `ICSV_IDX_MASK, 2'h0});
		mapped   = hit_ctrl | hit_stat | hit_mask;
	end

	// admission: level at or above threshold, nothing while disabled;
	// the lowest_priority_sw_request flag does not change admission; its entry leaves threshold code 0
	always_comb begin
		admit = req.valid & ~dis_q & ~hold_q
			& (req.level >= thr_q);
		// threshold code that a new service routine leaves behind
		if (req.lowest_priority_sw_request) begin
			new_thr = 2'h0;
		end else if (req.level == 2'h3) begin
			new_thr = 2'h3;
		end else begin
			new_thr = req.level + 2'h1;
		end
	end

	// read image of the control register
	always_comb begin
		ctrl_rd = {core_irq,
			thr_q,
			vec_q,
			dis_q,
			`ICSV_RSV_ONES,
			`ICSV_RSV_ZEROS};
	end

	////////////////////////////////////////////////////////////////////////
	// presenter: offers admitted request to the core until it enters the
	// routine or disable withdraws it; threshold and vector are caught only at that entry
	always_comb begin
		st_d      = st_q;
		hold_d    = 1'h0;
		thr_d     = thr_q;
		vec_d     = vec_q;
		vab_d     = vab_q;
		lvl_d     = lvl_q;
		lvl_thr_d = lvl_thr_q;
		case (st_q)
			// waiting for an admissible request
			icsv_pkg::ST_IDLE: begin
				if (admit) begin
					st_d      = icsv_pkg::ST_PRESENT;
					vab_d     = req.addr;
					lvl_d     = req.level;
					lvl_thr_d = new_thr;
				end
			end
			// request on the core pins
			icsv_pkg::ST_PRESENT: begin
				if (core_ack) begin
					st_d  = icsv_pkg::ST_IDLE;
					thr_d = lvl_thr_q;
					vec_d = vab_q[7:1];
				end else if (dis_q) begin
					// disable withdraws a pending offer
					st_d = icsv_pkg::ST_IDLE;
				end
			end
			default: begin
				st_d = icsv_pkg::ST_IDLE;
			end
		endcase
	end

	// presenter registers; reset forces the reset vector
	always_ff @(posedge clk) begin
		if (reset) begin
			st_q      <= icsv_pkg::ST_IDLE;
			hold_q    <= `ICSV_HOLD_EDGES;
			thr_q     <= `ICSV_RST_THR;
			vec_q     <= `ICSV_RST_VEC;
			vab_q     <= RESET_VEC;
			lvl_q     <= 2'h0;
			lvl_thr_q <= 2'h0;
		end else if (ce) begin
			st_q      <= st_d;
			hold_q    <= hold_d;
			thr_q     <= thr_d;
			vec_q     <= vec_d;
			vab_q     <= vab_d;
			lvl_q     <= lvl_d;
			lvl_thr_q <= lvl_thr_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// software registers and apb answer
	// events: a request entered service, a request refused by disable
	always_comb begin
		ev = '0;
		ev[`ICSV_EV_TAKEN] = (st_q == icsv_pkg::ST_PRESENT) & core_ack;
		ev[`ICSV_EV_BLOCK] = req.valid & dis_q;
	end

	// one wait state: the answer is registered, so pready rises in the
	// second access cycle; writes and read-clears act when it completes
	always_comb begin
		dis_d  = dis_q;
		mask_d = mask_q;
		stat_d = stat_q;
		rdy_d  = acc;
		rd_d   = rd_q;
		err_d  = acc & ~mapped;
		if (acc) begin
			if (pwrite | ~mapped) begin
				rd_d = 32'h0;
			end else if (hit_ctrl) begin
				rd_d = {16'h0, ctrl_rd};
			end else if (hit_stat) begin
				rd_d = {30'h0, stat_q};
			end else begin
				rd_d = {30'h0, mask_q};
			end
		end
		if (done & pwrite & hit_ctrl) begin
			// only the disable bit takes the written value
			dis_d = pwrite & pwdata[`ICSV_B_DIS];
		end
		if (done & pwrite & hit_mask) begin
			mask_d = pwdata[`ICSV_EV_W-1:0];
		end
		if (done & ~pwrite & hit_stat) begin
			stat_d = '0;
		end
		// set wins over a clear in the same cycle
		stat_d = stat_d | ev;
		irq_d  = |(stat_d & mask_d);
	end

	// register file flops
	always_ff @(posedge clk) begin
		if (reset) begin
			dis_q  <= `ICSV_RST_DIS;
			mask_q <= `ICSV_RST_MASK;
			stat_q <= '0;
			irq_q  <= 1'h0;
			rdy_q  <= 1'h0;
			rd_q   <= 32'h0;
			err_q  <= 1'h0;
		end else if (ce) begin
			dis_q  <= dis_d;
			mask_q <= mask_d;
			stat_q <= stat_d;
			irq_q  <= irq_d;
			rdy_q  <= rdy_d;
			rd_q   <= rd_d;
			err_q  <= err_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs, all from flops
	always_comb begin
		core_irq           = (st_q == icsv_pkg::ST_PRESENT);
		core_level         = lvl_q;
		vector_address_bus = vab_q;
		pready             = rdy_q;
		prdata             = rd_q;
		pslverr            = err_q;
		irq                = irq_q;
	end

endmodule : icsv_ctrl
`default_nettype wire

// file: verification/icsv_properties.sv
// port assertions for the interrupt control and status block
`timescale 1ns/1ps
`default_nettype none
module icsv_properties #(parameter logic [20:0] RESET_VEC = 21'h0) (
	input wire logic                clk, reset, ce, psel, penable, pwrite,
	input wire logic                pready, pslverr, core_ack, core_irq, irq,
	input wire logic [11:0]         paddr,
	input wire logic [31:0]         pwdata, prdata,
	input wire icsv_pkg::icsv_req_t req,
	input wire logic [1:0]          core_level,
	input wire logic [20:0]         vector_address_bus
);
	logic dis_q, dis_d; // shadow of the disable bit, kept from apb writes
	wire  acc = psel && penable && pready && paddr == 12'h058; // control access
	always_comb dis_d = reset ? 1'h0 : acc && pwrite ? pwdata[5] : dis_q;
	always_ff @(posedge clk) dis_q <= dis_d;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_rst_vector: assert property (disable iff (1'h0) reset |=>
		vector_address_bus == RESET_VEC) else $error("no reset vector");
	a_rel_hold: assert property ($fell(reset) |-> vector_address_bus == RESET_VEC
		##1 vector_address_bus == RESET_VEC) else $error("reset vector dropped early");
	a_rst_quiet: assert property (disable iff (1'h0) reset |=>
		!core_irq && !irq && !pready) else $error("outputs busy in reset");
	a_ack_drop: assert property (core_irq && core_ack |=> !core_irq)
		else $error("request kept after entry");
	a_offer_vec: assert property ($rose(core_irq) |-> vector_address_bus ==
		$past(req.addr) && core_level == $past(req.level)) else $error("wrong vector");
	a_dis_block: assert property (dis_q |=> !core_irq)
		else $error("request passed while disabled");
	a_rd_fixed: assert property (acc && !pwrite |-> prdata[15] == $past(core_irq) &&
		prdata[5] == dis_q && prdata[4:0] == 5'h1c) else $error("control read wrong");
	a_unmapped: assert property (pready && !(paddr inside {12'h058, 12'h05c, 12'h060})
		|-> pslverr && prdata == 32'h0) else $error("unmapped access answered");
endmodule : icsv_properties
bind icsv_ctrl icsv_properties #(.RESET_VEC(RESET_VEC)) u_props (.clk, .reset, .ce, .psel,
	.penable, .pwrite, .pready, .pslverr, .core_ack, .core_irq, .irq, .paddr, .pwdata,
	.prdata, .req, .core_level, .vector_address_bus);
`default_nettype wire

// file: verification/icsv_core_model.sv
// core stand-in: enters the routine of each presented request after a set delay
`timescale 1ns/1ps
`default_nettype none
module icsv_core_model (
	input wire logic       clk, reset, core_irq,
	input wire logic [3:0] delay,
	output logic           core_ack
);
	logic [3:0] cnt_q, cnt_d; // cycles the offer has stood
	// restart on every offer so each one waits the whole delay
	always_comb cnt_d = (reset || !core_irq || core_ack) ? 4'h0 : cnt_q + 4'h1;
	always_ff @(posedge clk) cnt_q <= cnt_d;
	assign core_ack = core_irq && cnt_q == delay;
endmodule : icsv_core_model
`default_nettype wire

// file: verification/testbench.sv
// self-checking bench for the interrupt control and status block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam logic [20:0] RV = 21'h0a5a5a; // reset vector under test
	localparam logic [11:0] AC = 12'h058, AS = 12'h05c, AM = 12'h060; // ctrl, status, mask
	logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, err;
	logic pready, pslverr, core_ack, core_irq, irq;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [1:0] core_level;
	logic [3:0] delay = 0;
	logic [20:0] vector_address_bus;
	icsv_pkg::icsv_req_t req = '0;
	int fails = 0, samples_checked = 0;
	icsv_ctrl #(.RESET_VEC(RV)) uut (.clk, .reset, .ce(1'h1), .psel, .penable, .pwrite,
		.paddr, .pwdata, .pready, .prdata, .pslverr, .req, .core_ack, .core_irq,
		.core_level, .vector_address_bus, .irq);
	icsv_core_model core (.clk, .reset, .core_irq, .delay, .core_ack);
	always #5 clk = ~clk;
	task automatic chk(input logic [31:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// request stays steady until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk) penable <= 1'h1;
		do @(posedge clk); while (!pready);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask
	task automatic rdc(input logic [1:0] th, input logic [20:0] ad, input logic ds);
		apb(1'h0, AC, 32'h0);
		chk(rd, {16'h0, 1'h0, th, ad[7:1], ds, 5'h1c});
	endtask
	task automatic rds(input logic [31:0] ex);
		apb(1'h0, AS, 32'h0);
		chk(rd, ex);
	endtask
	// offer held until entered or plainly refused
	task automatic offer(input logic [1:0] lv, input logic [20:0] ad, input logic sw, tk);
		int n;
		n = 0;
		req <= '{1'h1, sw, lv, ad};
		do @(posedge clk); while (!(core_irq && core_ack) && ++n < 8);
		chk(n < 8, tk);
		if (tk)
			chk(vector_address_bus, ad);
		req <= '0;
		@(posedge clk);
	endtask
	task automatic t_reset;
		repeat (2) @(posedge clk);
		chk(vector_address_bus, RV);
		reset <= 1'h0;
		repeat (2) begin
			@(posedge clk);
			chk(vector_address_bus, RV);
		end
		rdc(2'h0, 21'h0, 1'h0);
		rds(32'h0);
		apb(1'h0, AM, 32'h0);
		chk(rd, 32'h0);
	endtask
	task automatic t_levels;
		offer(2'h0, 21'h000011, 1'h1, 1'h1);
		rdc(2'h0, 21'h000011, 1'h0);
		for (int l = 0; l < 4; l++) begin
			if (l > 0)
				offer(2'(l - 1), 21'h000040, 1'h0, 1'h0);
			offer(2'(l), 21'h1f0020 + 21'(l * 6), 1'h0, 1'h1);
			rdc(l == 3 ? 2'h3 : 2'(l + 1), 21'h1f0020 + 21'(l * 6), 1'h0);
		end
	endtask
	// slow core; a refused offer must not touch the fields
	task automatic t_irq;
		delay <= 4'h5;
		offer(2'h2, 21'h000054, 1'h0, 1'h0);
		rdc(2'h3, 21'h1f0032, 1'h0);
		rds(32'h1);
		apb(1'h1, AM, 32'h3);
		offer(2'h3, 21'h00007e, 1'h0, 1'h1);
		apb(1'h0, AM, 32'h0);
		chk(rd, 32'h3);
		chk(irq, 1'h1);
		rds(32'h1);
		@(posedge clk);
		chk(irq, 1'h0);
		offer(2'h3, 21'h00007e, 1'h0, 1'h1);
		chk(irq, 1'h1);
		rds(32'h1);
	endtask
	task automatic t_disable;
		apb(1'h1, AC, 32'hffffffff);
		rdc(2'h3, 21'h00007e, 1'h1);
		offer(2'h3, 21'h000100, 1'h0, 1'h0);
		rds(32'h2);
		apb(1'h1, AC, 32'h1c);
		offer(2'h3, 21'h000100, 1'h0, 1'h1);
		rdc(2'h3, 21'h000100, 1'h0);
		apb(1'h0, 12'h064, 32'h0);
		chk(err, 1'h1);
		chk(rd, 32'h0);
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (18) @(posedge clk);
		t_reset;
		t_levels;
		t_irq;
		t_disable;
		reset <= 1'h1;
		t_reset;
		offer(2'h1, 21'h000022, 1'h1, 1'h1);
		results;
	end
	initial begin
		repeat (3000) @(posedge clk);
		fails++;
		results;
	end
endmodule : testbench
`default_nettype wire
